/* File: common/pcu_pkg.sv */
// Package for the program counter unit: register offsets, widths, vectors.
// Assumes an APB slave with 32-bit data, one register per aligned word.
`default_nettype none
package pcu_pkg;
   localparam int PC_W = 21;
   localparam int FETCH_W = 16;
   localparam logic [20:0] PC_RESET = 21'h000000;
   localparam logic [20:0] VEC_RESET = 21'h000000;
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;
   localparam logic [20:0] PC_STEP = 21'h000002;
   // Implemented program memory: 16 Kbytes, 8192 words
   localparam logic [20:0] MEM_BYTES = 21'h004000;
   localparam int MEM_WORDS = 8192;
   localparam int MEM_AW = 13;
   localparam logic [15:0] NOP_WORD = 16'h0000;
   // Register map
   localparam logic [11:0] OFS_PC_LOW = 12'h000;
   localparam logic [11:0] OFS_PC_HIGH_LATCH = 12'h004;
   localparam logic [11:0] OFS_PC_UPPER_LATCH = 12'h008;
   localparam logic [11:0] OFS_CTRL = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_TOS = 12'h014;
   localparam logic [11:0] OFS_RETURN_STACK_POINTER = 12'h018;
   localparam logic [11:0] OFS_TARGET = 12'h01C;
   localparam logic [11:0] OFS_MEM_ADDR = 12'h020;
   localparam logic [11:0] OFS_MEM_DATA = 12'h024;
   // Control register bits
   localparam int CTRL_STEP = 0;
   localparam int CTRL_JUMP = 1;
   localparam int CTRL_CALL = 2;
   localparam int CTRL_RETURN = 3;
   localparam int CTRL_WAKE = 4;
   localparam int CTRL_HIGH_PRIORITY_GLOBAL_ENABLE = 5;
   localparam int CTRL_LOW_PRIORITY_GLOBAL_ENABLE = 6;
   localparam int CTRL_HIPRI = 7;
   localparam logic [1:0] GIE_RESET = 2'h0;
   localparam logic [4:0] SP_RESET = 5'h00;
   localparam logic [4:0] SP_MAX = 5'h1F;
endpackage : pcu_pkg
`default_nettype wire

/* File: rtl/pcu_prog_mem.sv */
// Program memory array in flip-flops, 8192 words of 16 bits.
// Assumes fetch and data-side write ports run in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module pcu_prog_mem
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [20:0] fetch_addr,
   output logic      [15:0] fetch_word,
   input  wire logic        wr_en,
   input  wire logic [12:0] wr_index,
   input  wire logic [15:0] wr_data
);
   logic [15:0] mem [pcu_pkg::MEM_WORDS];
   logic [15:0] next_fetch_word;

   // Fetch port: above 16 Kbytes reads zero
   always_comb
   begin
      if (fetch_addr >= pcu_pkg::MEM_BYTES)
         next_fetch_word = pcu_pkg::NOP_WORD;
      else
         next_fetch_word = mem[fetch_addr[13:1]];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fetch_word <= pcu_pkg::NOP_WORD;
      else
         fetch_word <= next_fetch_word;
   end

   // Separate write port, usable in the same cycle as a fetch
   always_ff @(posedge pclk)
   begin
      if (wr_en)
         mem[wr_index] <= wr_data;
   end
endmodule // pcu_prog_mem
`default_nettype wire

/* File: rtl/pcu_top.sv */
// Program counter unit: 21-bit counter, holding latches, vectors, fetch.
// Assumes an APB master on pclk; pready is always high.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcu_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [20:0] pc_out,
   output logic      [15:0] fetch_word
);
   logic        acc;
   logic        wr;
   logic        rd;
   logic [20:0] pc;
   logic [20:0] next_pc;
   logic [7:0]  high_latch;
   logic [7:0]  next_high_latch;
   logic [4:0]  upper_latch;
   logic [4:0]  next_upper_latch;
   logic [1:0]  gie;
   logic [1:0]  next_gie;
   logic [20:0] target;
   logic [20:0] next_target;
   logic [20:0] tos;
   logic [20:0] next_tos;
   logic [4:0]  sp;
   logic [4:0]  next_sp;
   logic [12:0] mem_index;
   logic [12:0] next_mem_index;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        mem_wr;
   logic [7:0]  c;
   logic        setup;
   logic        rd_setup;
   logic        wr_setup;
   logic        ctrl_wr;
   logic        wake_go;
   logic        do_wake;
   logic        do_call;
   logic        do_return;
   logic        do_jump;
   logic        do_step;

   // ----------------------------------------
   // Bus phase decode
   // ----------------------------------------
   // State moves on the access edge; the answer is prepared in setup
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign setup = psel && !penable;
   assign rd_setup = setup && !pwrite;
   assign wr_setup = setup && pwrite;
   assign c = pwdata[7:0];
   assign mem_wr = wr && (paddr == pcu_pkg::OFS_MEM_DATA);
   assign ctrl_wr = wr && (paddr == pcu_pkg::OFS_CTRL);
   assign wake_go = c[pcu_pkg::CTRL_HIGH_PRIORITY_GLOBAL_ENABLE] || c[pcu_pkg::CTRL_LOW_PRIORITY_GLOBAL_ENABLE];

   // ----------------------------------------
   // Control command decode
   // ----------------------------------------
   // One command per control write: wake, call, return, jump, then step
   always_comb
   begin
      do_wake = 1'b0;
      do_call = 1'b0;
      do_return = 1'b0;
      do_jump = 1'b0;
      do_step = 1'b0;
      if (ctrl_wr)
      begin
         if (c[pcu_pkg::CTRL_WAKE])
            do_wake = 1'b1;
         else if (c[pcu_pkg::CTRL_CALL])
            do_call = 1'b1;
         else if (c[pcu_pkg::CTRL_RETURN])
            do_return = 1'b1;
         else if (c[pcu_pkg::CTRL_JUMP])
            do_jump = 1'b1;
         else if (c[pcu_pkg::CTRL_STEP])
            do_step = 1'b1;
      end
   end

   // ----------------------------------------
   // Counter, latches and stack top
   // ----------------------------------------
   always_comb
   begin
      next_pc = pc;
      next_high_latch = high_latch;
      next_upper_latch = upper_latch;
      next_gie = gie;
      next_target = target;
      next_tos = tos;
      next_sp = sp;
      next_mem_index = mem_index;
      if (rd && paddr == pcu_pkg::OFS_PC_LOW)
      begin
         next_high_latch = pc[15:8];
         next_upper_latch = pc[20:16];
      end
      if (wr)
      begin
         case (paddr)
            pcu_pkg::OFS_PC_LOW:
               next_pc = {upper_latch, high_latch, c[7:1], 1'b0};
            pcu_pkg::OFS_PC_HIGH_LATCH:
               next_high_latch = c;
            pcu_pkg::OFS_PC_UPPER_LATCH:
               next_upper_latch = c[4:0];
            pcu_pkg::OFS_TARGET:
               next_target = {pwdata[20:1], 1'b0};
            pcu_pkg::OFS_TOS:
               next_tos = {pwdata[20:1], 1'b0};
            pcu_pkg::OFS_RETURN_STACK_POINTER:
               next_sp = pwdata[4:0];
            pcu_pkg::OFS_MEM_ADDR:
               next_mem_index = pwdata[12:0];
            pcu_pkg::OFS_CTRL:
            begin
               next_gie = {c[pcu_pkg::CTRL_LOW_PRIORITY_GLOBAL_ENABLE], c[pcu_pkg::CTRL_HIGH_PRIORITY_GLOBAL_ENABLE]};
               if (do_wake)
               begin
                  if (wake_go)
                  begin
                     next_tos = pc;
                     // Pointer saturates at both ends; no full or underflow flags
                     if (sp != pcu_pkg::SP_MAX)
                        next_sp = sp + 5'h01;
                     if (c[pcu_pkg::CTRL_HIPRI])
                        next_pc = pcu_pkg::VEC_HIGH;
                     else
                        next_pc = pcu_pkg::VEC_LOW;
                  end
                  // Wake with both enables clear resumes at the next word
                  else
                     next_pc = pc + pcu_pkg::PC_STEP;
               end
               else if (do_call)
               begin
                  // Latches untouched on call
                  next_tos = pc + pcu_pkg::PC_STEP;
                  if (sp != pcu_pkg::SP_MAX)
                     next_sp = sp + 5'h01;
                  next_pc = target;
               end
               else if (do_return)
               begin
                  next_pc = tos;
                  if (sp != pcu_pkg::SP_RESET)
                     next_sp = sp - 5'h01;
               end
               else if (do_jump)
                  next_pc = target;
               else if (do_step)
                  next_pc = pc + pcu_pkg::PC_STEP;
            end
            default:
               next_pc = pc;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc <= pcu_pkg::VEC_RESET;
         high_latch <= 8'h00;
         upper_latch <= 5'h00;
         gie <= pcu_pkg::GIE_RESET;
         target <= pcu_pkg::PC_RESET;
         tos <= pcu_pkg::PC_RESET;
         sp <= pcu_pkg::SP_RESET;
         mem_index <= 13'h0000;
      end
      else
      begin
         pc <= next_pc;
         high_latch <= next_high_latch;
         upper_latch <= next_upper_latch;
         gie <= next_gie;
         target <= next_target;
         tos <= next_tos;
         sp <= next_sp;
         mem_index <= next_mem_index;
      end
   end

   // ----------------------------------------
   // APB read data
   // ----------------------------------------
   always_comb
   begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      if (rd_setup)
      begin
         case (paddr)
            // Middle and top bytes have no address of their own
            pcu_pkg::OFS_PC_LOW:
               next_prdata = {24'h000000, pc[7:0]};
            pcu_pkg::OFS_PC_HIGH_LATCH:
               next_prdata = {24'h000000, high_latch};
            pcu_pkg::OFS_PC_UPPER_LATCH:
               next_prdata = {27'h0000000, upper_latch};
            pcu_pkg::OFS_CTRL:
               next_prdata = {25'h0000000, gie, 5'h00};
            pcu_pkg::OFS_STATUS:
               next_prdata = {11'h000, pc};
            pcu_pkg::OFS_TOS:
               next_prdata = {11'h000, tos};
            pcu_pkg::OFS_RETURN_STACK_POINTER:
               next_prdata = {27'h0000000, sp};
            pcu_pkg::OFS_TARGET:
               next_prdata = {11'h000, target};
            pcu_pkg::OFS_MEM_ADDR:
               next_prdata = {19'h00000, mem_index};
            pcu_pkg::OFS_MEM_DATA:
               next_prdata = 32'h00000000;
            default:
               next_pslverr = 1'b1;
         endcase
      end
      else if (wr_setup)
      begin
         case (paddr)
            pcu_pkg::OFS_PC_LOW, pcu_pkg::OFS_PC_HIGH_LATCH,
            pcu_pkg::OFS_PC_UPPER_LATCH, pcu_pkg::OFS_CTRL,
            pcu_pkg::OFS_TOS, pcu_pkg::OFS_RETURN_STACK_POINTER, pcu_pkg::OFS_TARGET,
            pcu_pkg::OFS_MEM_ADDR, pcu_pkg::OFS_MEM_DATA:
               next_pslverr = 1'b0;
            default:
               next_pslverr = 1'b1;
         endcase
      end
   end

   // Answer registered from the setup phase, so prdata and pslverr
   // already stand at the access edge where pready is sampled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         pready <= 1'b1;
         pc_out <= pcu_pkg::PC_RESET;
      end
      else
      begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         pready <= 1'b1;
         pc_out <= next_pc;
      end
   end

   // ----------------------------------------
   // Program memory, fetched from the counter
   // ----------------------------------------
   pcu_prog_mem u_mem
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .fetch_addr (next_pc),
      .fetch_word (fetch_word),
      .wr_en      (mem_wr),
      .wr_index   (mem_index),
      .wr_data    (pwdata[15:0])
   );
endmodule // pcu_top
`default_nettype wire

/* File: bench/pcu_top_properties.sv */
// Checker for the program counter unit, bound to the top ports.
// Assumes zero or more wait states and one register per aligned word.
`timescale 1ns/1ps
`default_nettype none
module pcu_top_properties
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [20:0] pc_out,
   input wire logic [15:0] fetch_word
);
   logic [7:0] lh;
   logic [4:0] lu;
   logic [1:0] gie;
   wire logic  acc = psel && penable && pready;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr(logic [11:0] a);
      acc && pwrite && paddr == a;
   endsequence
   sequence s_wake(logic hi);
      s_wr(pcu_pkg::OFS_CTRL) ##0 (pwdata[4] && pwdata[7] == hi && |gie && gie == pwdata[6:5]);
   endsequence
   // Shadow latches, so a low-byte write can be predicted
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         lh  <= 8'h00;
         lu  <= 5'h00;
         gie <= 2'h0;
      end
      else if (acc && pwrite && paddr == pcu_pkg::OFS_PC_HIGH_LATCH)
         lh <= pwdata[7:0];
      else if (acc && pwrite && paddr == pcu_pkg::OFS_PC_UPPER_LATCH)
         lu <= pwdata[4:0];
      else if (acc && pwrite && paddr == pcu_pkg::OFS_CTRL)
         gie <= pwdata[6:5];
      else if (acc && !pwrite && paddr == pcu_pkg::OFS_PC_LOW)
      begin
         lh <= pc_out[15:8];
         lu <= pc_out[20:16];
      end
   a_pc_even : assert property (pc_out[0] == 1'b0)
      else $error("Counter bit zero set");
   a_reset_zero : assert property ($rose(presetn) |-> pc_out == 21'h000000)
      else $error("Counter not clear after reset");
   a_low_load : assert property (s_wr(pcu_pkg::OFS_PC_LOW) |=>
      pc_out == {$past(lu), $past(lh), $past(pwdata[7:0]) & 8'hFE}) else $error("Bad low load");
   a_step_two : assert property (s_wr(pcu_pkg::OFS_CTRL) ##0 (pwdata[7:0] == 8'h01) |=>
      pc_out == $past(pc_out) + pcu_pkg::PC_STEP) else $error("Step not two");
   a_wake_high : assert property (s_wake(1'b1) |=> pc_out == pcu_pkg::VEC_HIGH)
      else $error("High vector wrong");
   a_wake_low : assert property (s_wake(1'b0) |=> pc_out == pcu_pkg::VEC_LOW)
      else $error("Low vector wrong");
   a_above_zero : assert property (pc_out >= pcu_pkg::MEM_BYTES && $stable(pc_out) &&
      $past(pc_out, 2) == pc_out |-> fetch_word == 16'h0000) else $error("Fetch not zero");
   a_ready_high : assert property (pready) else $error("Ready low");
   a_unmapped_err : assert property (acc && paddr > pcu_pkg::OFS_MEM_DATA |-> pslverr)
      else $error("No error on unmapped");
endmodule // pcu_top_properties
`default_nettype wire

/* File: bench/pcu_mem_ref.sv */
// Reference program memory giving the expected fetch word.
// Assumes the bench mirrors every memory write into mem.
`timescale 1ns/1ps
`default_nettype none
module pcu_mem_ref
(
   input  wire logic [20:0] addr,
   output logic      [15:0] word
);
   logic [15:0] mem [8192];
   // Above the array the space reads as no-operation words
   assign word = (addr < pcu_pkg::MEM_BYTES) ? mem[addr[13:1]] : 16'h0000;
endmodule // pcu_mem_ref
`default_nettype wire

/* File: bench/tb_pcu_top.sv */
// Testbench for the program counter unit driven over APB.
// Assumes the package register map and the reference memory model.
`timescale 1ns/1ps
`default_nettype none
module tb_pcu_top;
   typedef struct packed {logic [1:0] k; logic [11:0] a; logic [23:0] d; logic [23:0] e;} pcu_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [20:0] pc_out;
   logic [15:0] fetch_word;
   logic [15:0] exp_word;
   logic [31:0] rd;
   logic        er;
   int          num_errors = 0;
   int          checked = 0;
   // Kind 0 read, 1 write and check counter, 2 write only
   pcu_row_t rows [19] = '{'{2'h1, 12'h004, 24'h12, 24'h0}, '{2'h1, 12'h008, 24'h01, 24'h0},
      '{2'h1, 12'h000, 24'h35, 24'h11234}, '{2'h1, 12'h00C, 24'h01, 24'h11236},
      '{2'h1, 12'h01C, 24'h100, 24'h11236}, '{2'h1, 12'h00C, 24'h02, 24'h100},
      '{2'h1, 12'h01C, 24'h3F0, 24'h100}, '{2'h1, 12'h00C, 24'h04, 24'h3F0},
      '{2'h0, 12'h014, 24'h0, 24'h102}, '{2'h1, 12'h00C, 24'h08, 24'h102},
      '{2'h0, 12'h004, 24'h0, 24'h12}, '{2'h0, 12'h008, 24'h0, 24'h01},
      '{2'h2, 12'h00C, 24'h20, 24'h0}, '{2'h1, 12'h00C, 24'hB0, 24'h8},
      '{2'h0, 12'h014, 24'h0, 24'h102}, '{2'h0, 12'h018, 24'h0, 24'h1},
      '{2'h2, 12'h00C, 24'h40, 24'h0}, '{2'h1, 12'h00C, 24'h50, 24'h18},
      '{2'h0, 12'h010, 24'h0, 24'h18}};
   pcu_top i_pcu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pc_out(pc_out), .fetch_word(fetch_word));
   pcu_mem_ref i_pcu_mem_ref (.addr(pc_out), .word(exp_word));
   initial forever #2.5 pclk = ~pclk;
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Read data is taken at the edge that completes the access; one idle edge follows
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   initial
   begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      wrap_up();
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].k != 2'h0, rows[i].a, {8'h00, rows[i].d});
         if (rows[i].k == 2'h0)
            chk("prdata", {8'h00, rows[i].e}, rd);
         else if (rows[i].k == 2'h1)
            chk("pc_out", {8'h00, rows[i].e}, {11'h0, pc_out});
      end
      apb(1'b1, 12'h020, 32'h1FFF);
      apb(1'b1, 12'h024, 32'hA5C3);
      i_pcu_mem_ref.mem[13'h1FFF] = 16'hA5C3;
      apb(1'b1, 12'h01C, 32'h3FFE);
      apb(1'b1, 12'h00C, 32'h2);
      repeat (2) @(posedge pclk);
      chk("fetch_word", {16'h0, exp_word}, {16'h0, fetch_word});
      apb(1'b1, 12'h01C, 32'h1ABCDE);
      apb(1'b1, 12'h00C, 32'h2);
      repeat (2) @(posedge pclk);
      chk("fetch_word", 32'h0, {16'h0, fetch_word});
      chk("pc_out", 32'h1ABCDE, {11'h0, pc_out});
      apb(1'b0, 12'h000, 32'h0);
      chk("pc_low_byte", 32'hDE, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("pc_high_latch", 32'hBC, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("pc_upper_latch", 32'h1A, rd);
      apb(1'b0, 12'h040, 32'h0);
      chk("pslverr", 32'h1, {31'h0, er});
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("pc_out", 32'h0, {11'h0, pc_out});
      presetn <= 1'b1;
      apb(1'b0, 12'h010, 32'h0);
      chk("status", 32'h0, rd);
      wrap_up();
   end
endmodule // tb_pcu_top
bind pcu_top pcu_top_properties i_pcu_top_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .fetch_word(fetch_word));
`default_nettype wire
